// >>> src/les_defines.vh
`ifndef LES_DEFINES_VH
`define LES_DEFINES_VH

// lane count and per-lane field widths
`define LES_LANES 4
`define LES_HDR_W 2
`define LES_BTF_W 8

// 2-bit sync header codes
`define LES_HDR_CTRL 2'h2
`define LES_HDR_DATA 2'h1

// recognised block type field codes
`define LES_BTF_IDLE 8'h78
`define LES_BTF_CC 8'h80
`define LES_BTF_CB 8'h84
`define LES_BTF_SEP 8'h1E

// block sync: good headers to lock, window length, bad limit within a window
`define LES_SYNC_GOOD_M1 7'h3F
`define LES_SYNC_WIN_M1 10'h3FF
`define LES_SYNC_BAD_M1 5'h0F

// clock and timers
`define LES_CLK_NS 50
`define LES_PARTNER_WAIT_NS 10000
`define LES_PARTNER_WAIT_CYC ((`LES_PARTNER_WAIT_NS + `LES_CLK_NS - 1) / `LES_CLK_NS)
`define LES_HOTPLUG_NS 100000
`define LES_HOTPLUG_CYC (`LES_HOTPLUG_NS / `LES_CLK_NS)
`define LES_SELF_RST_CYC 5'h10
`define LES_BOND_INTERVAL 18'h017C0
`define LES_BOND_LEN_M1 3'h3

// register offsets
`define LES_REG_CTRL 4'h0
`define LES_REG_STATUS 4'h4
`define LES_REG_MINOR_CNT 4'h8

// control and status fields
`define LES_CTRL_HOTPLUG_SEL 0
`define LES_CTRL_RESTART 1
`define LES_STAT_LINK_READY 4
`define LES_STAT_SEVERE 5
`define LES_CTRL_RESET 1'h0

`endif

// >>> src/les_link_status.v
// Operation
// [RL1] pulse minor fault on detected bit error
// [RL2] watch lanes for faults, flag severe fault
// [RL3] too many bad headers restarts lane alignment
// [RL4] severe fault triggers self reset and reinit
// [RL5] tx elastic buffer error raises severe fault
// [RL6] rx correction fifo error raises severe fault
// [RL7] invalid sync header gives minor fault pulse
// [RL8] unknown block type gives minor fault pulse
// [RL9] initialization starts automatically after any reset
// [RL10] one ready bit per initialised lane
// [RL11] link ready only after all stages done
// [RL12] user qualifies receive data with valid only
// [RL13] no user transmit while link not ready
// [RL14] no receive data until all lanes ready
// [RL15] simplex uses timer to judge partner ready
// [RL16] hotplug counter cleared by cc or btf
// [RL17] controller holds simplex tx until rx up
// [RL18] periodic bonding pattern every set interval
// [RL19] receiver comes up on bonding pattern
// [RL20] integrator bounds the larger interval setting
// [RL21] match flag shows crc compare result
// [RL22] crc strobe rides with last beat
// [RL23] crc strobe exactly one cycle per frame
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "les_defines.vh"

module les_block_sync
(
   // clock and reset
   input wire clk,
   input wire rst,
   // received header
   input wire hdr_valid,
   input wire hdr_bad,
   // alignment status
   output reg aligned_reg,
   output reg realign_reg
);

   reg [6:0] good_cnt_reg;
   reg [9:0] win_cnt_reg;
   reg [4:0] bad_cnt_reg;

   always @(posedge clk)
   begin
      if (rst)
      begin
         aligned_reg <= 1'b0;
         realign_reg <= 1'b0;
         good_cnt_reg <= 7'h00;
         win_cnt_reg <= 10'h000;
         bad_cnt_reg <= 5'h00;
      end
      else
      begin
         realign_reg <= 1'b0;
         if (hdr_valid)
         begin
            if (!aligned_reg)
            begin
               if (hdr_bad)
                  good_cnt_reg <= 7'h00;
               else if (good_cnt_reg == `LES_SYNC_GOOD_M1)
               begin
                  aligned_reg <= 1'b1;
                  good_cnt_reg <= 7'h00;
                  win_cnt_reg <= 10'h000;
                  bad_cnt_reg <= 5'h00;
               end
               else
                  good_cnt_reg <= good_cnt_reg + 7'h01;
            end
            else if (hdr_bad && bad_cnt_reg == `LES_SYNC_BAD_M1)
            begin
               // burst of bad headers: drop lock and hunt again
               aligned_reg <= 1'b0; // RL3
               realign_reg <= 1'b1; // RL3
               win_cnt_reg <= 10'h000;
               bad_cnt_reg <= 5'h00;
            end
            else if (win_cnt_reg == `LES_SYNC_WIN_M1)
            begin
               win_cnt_reg <= 10'h000;
               bad_cnt_reg <= 5'h00;
            end
            else
            begin
               win_cnt_reg <= win_cnt_reg + 10'h001;
               if (hdr_bad)
                  bad_cnt_reg <= bad_cnt_reg + 5'h01;
            end
         end
      end
   end

endmodule

module les_link_status
#(
   parameter [17:0] BOND_PATTERN_INTERVAL = `LES_BOND_INTERVAL
)
(
   // clock and reset
   input wire clk,
   input wire reset,
   // register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // transceiver fault pins, one bit per lane
   input wire [3:0] gt_tx_buf_fault,
   input wire [3:0] gt_rx_buf_fault,
   input wire [3:0] gt_lock_lost,
   // received blocks, one slice per lane
   input wire [3:0] rx_block_valid,
   input wire [7:0] rx_sync_header,
   input wire [31:0] rx_block_type,
   // receive user stream
   input wire rx_in_valid,
   input wire rx_in_last,
   input wire [31:0] rx_crc_received,
   input wire [31:0] rx_crc_computed,
   output reg rx_out_valid,
   output reg rx_out_last,
   output reg check_result_strobe,
   output reg check_match_flag,
   // transmit user stream
   input wire tx_user_valid,
   output wire tx_user_ready,
   output wire tx_user_take,
   output reg tx_bond_start,
   output wire tx_bond_busy,
   // status
   output reg minor_fault_pulse,
   output reg severe_fault_flag,
   output wire [3:0] lane_ready_vec,
   output wire [3:0] lane_realign,
   output reg link_ready
);

   localparam [3:0] S_LANE = 4'h1;
   localparam [3:0] S_BOND = 4'h2;
   localparam [3:0] S_WAIT = 4'h4;
   localparam [3:0] S_READY = 4'h8;
   localparam integer WAIT_CYC = `LES_PARTNER_WAIT_CYC;
   localparam integer HOTPLUG_CYC = `LES_HOTPLUG_CYC;
   localparam [7:0] WAIT_M1 = WAIT_CYC[7:0] - 8'h01;
   localparam [10:0] HOTPLUG_M1 = HOTPLUG_CYC[10:0] - 11'h001;

   reg [11:0] fault_s1_reg;
   reg [11:0] fault_s2_reg;
   reg [4:0] hold_cnt_reg;
   reg hotplug_sel_reg;
   reg restart_req_reg;
   reg [15:0] minor_cnt_reg;
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [7:0] wait_cnt_reg;
   reg [10:0] hotplug_cnt_reg;
   reg hotplug_trip_reg;
   reg [17:0] bond_cnt_reg;
   reg [2:0] bond_len_reg;
   reg bond_busy_reg;
   reg [3:0] hdr_bad;
   reg [3:0] btf_bad;
   reg cc_seen;
   reg cb_seen;
   reg btf_ok_seen;
   integer i;

   wire core_rst;
   wire any_fault;
   wire all_ready;
   wire minor_now;

   // fault pins come from the transceiver clocks
   always @(posedge clk)
   begin
      if (reset)
      begin
         fault_s1_reg <= 12'h000;
         fault_s2_reg <= 12'h000;
      end
      else
      begin
         fault_s1_reg <= {gt_lock_lost, gt_rx_buf_fault, gt_tx_buf_fault};
         fault_s2_reg <= fault_s1_reg;
      end
   end

   assign any_fault = |fault_s2_reg; // RL2 RL5 RL6

   // self reset: hold the link logic down, then start over
   assign core_rst = reset | (hold_cnt_reg != 5'h00); // RL4 RL9

   always @(posedge clk)
   begin
      if (reset)
      begin
         hold_cnt_reg <= 5'h00;
         severe_fault_flag <= 1'b0;
      end
      else
      begin
         severe_fault_flag <= any_fault; // RL2 RL5 RL6
         if (hold_cnt_reg != 5'h00)
            hold_cnt_reg <= hold_cnt_reg - 5'h01;
         else if (any_fault || restart_req_reg || hotplug_trip_reg)
            hold_cnt_reg <= `LES_SELF_RST_CYC; // RL4
      end
   end

   // header and block type checks per lane
   always @*
   begin
      hdr_bad = 4'h0;
      btf_bad = 4'h0;
      cc_seen = 1'b0;
      cb_seen = 1'b0;
      btf_ok_seen = 1'b0;
      for (i = 0; i < `LES_LANES; i = i + 1)
      begin
         if (rx_block_valid[i])
         begin
            if (rx_sync_header[i*2 +: 2] != `LES_HDR_CTRL && rx_sync_header[i*2 +: 2] != `LES_HDR_DATA)
               hdr_bad[i] = 1'b1; // RL7
            else if (rx_sync_header[i*2 +: 2] == `LES_HDR_CTRL)
            begin
               case (rx_block_type[i*8 +: 8])
                  `LES_BTF_CC:
                  begin
                     cc_seen = 1'b1;
                     btf_ok_seen = 1'b1;
                  end
                  `LES_BTF_CB:
                  begin
                     cb_seen = 1'b1;
                     btf_ok_seen = 1'b1;
                  end
                  `LES_BTF_IDLE, `LES_BTF_SEP:
                     btf_ok_seen = 1'b1;
                  default:
                     btf_bad[i] = 1'b1; // RL8
               endcase
            end
         end
      end
   end

   assign minor_now = |(hdr_bad | btf_bad); // RL1

   genvar g;
   generate
      for (g = 0; g < `LES_LANES; g = g + 1)
      begin : lane
         les_block_sync u_sync
         (
            .clk(clk),
            .rst(core_rst),
            .hdr_valid(rx_block_valid[g]),
            .hdr_bad(hdr_bad[g]),
            .aligned_reg(lane_ready_vec[g]), // RL10
            .realign_reg(lane_realign[g]) // RL3
         );
      end
   endgenerate

   assign all_ready = &lane_ready_vec;

   always @(posedge clk)
   begin
      if (core_rst)
         minor_fault_pulse <= 1'b0;
      else
         minor_fault_pulse <= minor_now; // RL1 RL7 RL8
   end

   // link bring-up sequence
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         S_LANE:
            if (all_ready)
               state_next = S_BOND;
         S_BOND:
            if (!all_ready)
               state_next = S_LANE;
            else if (cb_seen)
               state_next = S_WAIT; // RL19
         S_WAIT:
            if (!all_ready)
               state_next = S_LANE;
            else if (wait_cnt_reg == WAIT_M1)
               state_next = S_READY; // RL15
         S_READY:
            if (!all_ready)
               state_next = S_LANE;
         default:
            state_next = S_LANE;
      endcase
   end

   always @(posedge clk)
   begin
      if (core_rst)
      begin
         state_reg <= S_LANE; // RL9
         wait_cnt_reg <= 8'h00;
         link_ready <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         link_ready <= (state_next == S_READY); // RL11
         if (state_reg == S_WAIT)
            wait_cnt_reg <= wait_cnt_reg + 8'h01;
         else
            wait_cnt_reg <= 8'h00;
      end
   end

   // hotplug watch: no cc block (any known block type when hotplug_sel_reg is set) from the partner restarts the link
   always @(posedge clk)
   begin
      if (core_rst)
      begin
         hotplug_cnt_reg <= 11'h000;
         hotplug_trip_reg <= 1'b0;
      end
      else
      begin
         hotplug_trip_reg <= 1'b0;
         if (state_reg == S_LANE)
            hotplug_cnt_reg <= 11'h000;
         else if (hotplug_sel_reg ? btf_ok_seen : cc_seen)
            hotplug_cnt_reg <= 11'h000; // RL16
         else if (hotplug_cnt_reg == HOTPLUG_M1)
         begin
            hotplug_cnt_reg <= 11'h000;
            hotplug_trip_reg <= 1'b1;
         end
         else
            hotplug_cnt_reg <= hotplug_cnt_reg + 11'h001;
      end
   end

   // periodic bonding pattern on the transmit side
   always @(posedge clk)
   begin
      if (core_rst)
      begin
         bond_cnt_reg <= 18'h00000;
         tx_bond_start <= 1'b0;
         bond_len_reg <= 3'h0;
         bond_busy_reg <= 1'b0;
      end
      else
      begin
         tx_bond_start <= (bond_cnt_reg == 18'h00000); // RL18
         if (bond_cnt_reg == BOND_PATTERN_INTERVAL - 18'h00001)
            bond_cnt_reg <= 18'h00000; // RL18
         else
            bond_cnt_reg <= bond_cnt_reg + 18'h00001;
         if (bond_cnt_reg == 18'h00000)
         begin
            bond_busy_reg <= 1'b1;
            bond_len_reg <= 3'h0;
         end
         else if (bond_busy_reg)
         begin
            if (bond_len_reg == `LES_BOND_LEN_M1)
               bond_busy_reg <= 1'b0;
            bond_len_reg <= bond_len_reg + 3'h1;
         end
      end
   end

   assign tx_bond_busy = bond_busy_reg;
   assign tx_user_ready = link_ready & ~bond_busy_reg; // RL13
   assign tx_user_take = tx_user_valid & tx_user_ready; // RL13

   // receive stream gating and crc result
   always @(posedge clk)
   begin
      if (core_rst)
      begin
         rx_out_valid <= 1'b0;
         rx_out_last <= 1'b0;
         check_result_strobe <= 1'b0;
         check_match_flag <= 1'b0;
      end
      else
      begin
         rx_out_valid <= rx_in_valid & all_ready; // RL14
         rx_out_last <= rx_in_valid & rx_in_last & all_ready; // RL14 RL22
         check_result_strobe <= rx_in_valid & rx_in_last & all_ready; // RL22 RL23
         if (rx_in_valid && rx_in_last && all_ready)
            check_match_flag <= (rx_crc_received == rx_crc_computed); // RL21
      end
   end

   // register port
   always @(posedge clk)
   begin
      if (reset)
      begin
         hotplug_sel_reg <= `LES_CTRL_RESET;
         restart_req_reg <= 1'b0;
         minor_cnt_reg <= 16'h0000;
         reg_rdata <= 32'h00000000;
      end
      else
      begin
         restart_req_reg <= 1'b0;
         if (reg_wr && reg_addr == `LES_REG_CTRL)
         begin
            hotplug_sel_reg <= reg_wdata[`LES_CTRL_HOTPLUG_SEL];
            restart_req_reg <= reg_wdata[`LES_CTRL_RESTART];
         end
         if (minor_fault_pulse && minor_cnt_reg != 16'hFFFF)
            minor_cnt_reg <= minor_cnt_reg + 16'h0001;
         else if (reg_wr && reg_addr == `LES_REG_MINOR_CNT)
            minor_cnt_reg <= 16'h0000;
         reg_rdata <= 32'h00000000;
         if (reg_rd)
         begin
            case (reg_addr)
               `LES_REG_CTRL:
                  reg_rdata <= {31'h00000000, hotplug_sel_reg};
               `LES_REG_STATUS:
                  reg_rdata <= {26'h0000000, severe_fault_flag, link_ready, lane_ready_vec};
               `LES_REG_MINOR_CNT:
                  reg_rdata <= {16'h0000, minor_cnt_reg};
               default:
                  reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// >>> src/les_pad.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> bench/les_far_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "les_defines.vh"
module les_far_end
(
   // clock
   input wire logic clk,
   // pattern select from the bench
   input wire logic [2:0] mode,
   // lane blocks toward the block
   output logic [3:0] rx_block_valid,
   output logic [7:0] rx_sync_header,
   output logic [31:0] rx_block_type
);
   logic [2:0] k = 3'h0;
   logic [1:0] h;
   logic [7:0] t;
   always @(posedge clk)
      k <= k + 3'h1;
   // mode 0: lanes silent with a moving pattern, 1: traffic with cc and cb, 2: idle only,
   // 3: broken header, 4: unknown block type
   always_comb
   begin
      rx_block_valid = (mode == 3'h0) ? 4'h0 : 4'hF;
      h = `LES_HDR_CTRL;
      t = `LES_BTF_IDLE;
      case (mode)
         3'h0:
         begin
            h = k[1:0];
            t = {5'h15, k};
         end
         3'h1:
         begin
            h = (k[1:0] == 2'h0) ? `LES_HDR_CTRL : `LES_HDR_DATA;
            t = k[2] ? `LES_BTF_CB : `LES_BTF_CC;
         end
         3'h3: h = 2'h0;
         3'h4: t = 8'h55;
         default: t = `LES_BTF_IDLE;
      endcase
      rx_sync_header = {4{h}};
      rx_block_type = {4{t}};
   end
endmodule
`default_nettype wire

// >>> bench/les_link_status_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "les_defines.vh"
module les_link_status_checker
#(
   parameter [17:0] BOND_PATTERN_INTERVAL = `LES_BOND_INTERVAL
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // inputs
   input wire logic [3:0] gt_tx_buf_fault,
   input wire logic [3:0] gt_rx_buf_fault,
   input wire logic [3:0] gt_lock_lost,
   input wire logic [3:0] rx_block_valid,
   input wire logic [7:0] rx_sync_header,
   input wire logic [31:0] rx_block_type,
   input wire logic rx_in_valid,
   input wire logic rx_in_last,
   input wire logic [31:0] rx_crc_received,
   input wire logic [31:0] rx_crc_computed,
   // outputs
   input wire logic rx_out_valid,
   input wire logic rx_out_last,
   input wire logic check_result_strobe,
   input wire logic check_match_flag,
   input wire logic tx_user_take,
   input wire logic tx_bond_start,
   input wire logic minor_fault_pulse,
   input wire logic severe_fault_flag,
   input wire logic [3:0] lane_ready_vec,
   input wire logic link_ready
);
   logic bad;
   logic [1:0] age;
   logic [17:0] since;
   wire fault_any = |{gt_tx_buf_fault, gt_rx_buf_fault, gt_lock_lost};
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // any lane with a broken header or an unknown control type this cycle
   always_comb
   begin
      bad = 1'b0;
      for (int i = 0; i < 4; i++)
         if (rx_block_valid[i])
         begin
            if (rx_sync_header[2*i+:2] != `LES_HDR_CTRL && rx_sync_header[2*i+:2] != `LES_HDR_DATA)
               bad = 1'b1;
            else if (rx_sync_header[2*i+:2] == `LES_HDR_CTRL && !(rx_block_type[8*i+:8] inside
                     {`LES_BTF_IDLE, `LES_BTF_CC, `LES_BTF_CB, `LES_BTF_SEP}))
               bad = 1'b1;
         end
   end
   always_ff @(posedge clk)
   begin
      age <= reset ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
      since <= (reset || tx_bond_start) ? {17'h0, !reset} : since + 18'h1;
   end
   AST_SEVERE: assert property (age == 2'h3 |-> severe_fault_flag == $past(fault_any, 3))
      else $error("severe flag does not follow fault pins");
   AST_SELF_RESET: assert property ($rose(severe_fault_flag) |-> ##[1:3] !link_ready)
      else $error("link stays up after severe fault");
   AST_LINK: assert property (link_ready |-> $past(&lane_ready_vec))
      else $error("link ready without all lanes");
   AST_TX_GATE: assert property (tx_user_take |-> link_ready)
      else $error("user data taken while link down");
   AST_RX_GATE: assert property (rx_out_valid |-> $past(rx_in_valid && (&lane_ready_vec)))
      else $error("receive data before all lanes ready");
   AST_STROBE_LAST: assert property (check_result_strobe |-> rx_out_last && rx_out_valid)
      else $error("check strobe apart from last beat");
   AST_STROBE_CAUSE: assert property (check_result_strobe |-> $past(rx_in_valid && rx_in_last))
      else $error("check strobe without a frame end");
   AST_MATCH: assert property (check_result_strobe |->
      check_match_flag == ($past(rx_crc_received) == $past(rx_crc_computed)))
      else $error("match flag wrong");
   AST_MINOR: assert property ($past(|lane_ready_vec) && (|lane_ready_vec) |->
      minor_fault_pulse == $past(bad))
      else $error("minor fault pulse wrong");
   AST_BOND: assert property (tx_bond_start && link_ready && $past(link_ready) |->
      since == BOND_PATTERN_INTERVAL)
      else $error("bonding pattern interval wrong");
endmodule
bind les_link_status les_link_status_checker #(.BOND_PATTERN_INTERVAL(BOND_PATTERN_INTERVAL)) u_chk
   (.clk, .reset, .gt_tx_buf_fault, .gt_rx_buf_fault, .gt_lock_lost, .rx_block_valid, .rx_sync_header,
    .rx_block_type, .rx_in_valid, .rx_in_last, .rx_crc_received, .rx_crc_computed, .rx_out_valid,
    .rx_out_last, .check_result_strobe, .check_match_flag, .tx_user_take, .tx_bond_start,
    .minor_fault_pulse, .severe_fault_flag, .lane_ready_vec, .link_ready);
`default_nettype wire

// >>> bench/les_link_status_tb.sv
`timescale 1ns/10ps
`default_nettype none
module les_link_status_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rx_in_valid = 1'b0, rx_in_last = 1'b0, tx_user_valid = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, rx_crc_received = 32'h0, rx_crc_computed = 32'h0, reg_rdata;
   logic [11:0] fp = 12'h0;
   logic [2:0] mode = 3'h0;
   logic [3:0] rx_block_valid, lane_ready_vec, lane_realign;
   logic [7:0] rx_sync_header;
   logic [31:0] rx_block_type;
   logic rx_out_valid, rx_out_last, check_result_strobe, check_match_flag, tx_user_ready, tx_user_take;
   logic tx_bond_start, tx_bond_busy, minor_fault_pulse, severe_fault_flag, link_ready;
   int n_fail = 0;
   int comparisons = 0;
   int n;
   les_link_status #(.BOND_PATTERN_INTERVAL(18'h017C0)) u_les_link_status
      (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gt_tx_buf_fault(fp[3:0]),
       .gt_rx_buf_fault(fp[7:4]), .gt_lock_lost(fp[11:8]), .rx_block_valid, .rx_sync_header,
       .rx_block_type, .rx_in_valid, .rx_in_last, .rx_crc_received, .rx_crc_computed, .rx_out_valid,
       .rx_out_last, .check_result_strobe, .check_match_flag, .tx_user_valid, .tx_user_ready,
       .tx_user_take, .tx_bond_start, .tx_bond_busy, .minor_fault_pulse, .severe_fault_flag,
       .lane_ready_vec, .lane_realign, .link_ready);
   les_far_end u_les_far_end (.clk, .mode, .rx_block_valid, .rx_sync_header, .rx_block_type);
   always #25 clk = ~clk;
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input logic ok, input string m);
      begin
         comparisons++;
         if (ok !== 1'b1)
         begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
         end
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata === e, "register read");
      end
   endtask
   // bounded wait for the link to reach the wanted state
   task wait_link(input logic want, input int lim);
      begin
         n = 0;
         while (link_ready !== want)
         begin
            @(posedge clk);
            #1 n++;
            if (n > lim)
            begin
               chk(1'b0, "link wait timed out");
               finish_test;
            end
         end
      end
   endtask
   // two-beat frame, result checked the cycle after the last beat
   task frame(input logic [31:0] r, input logic [31:0] c, input logic up);
      begin
         @(posedge clk);
         rx_in_valid <= 1'b1;
         @(posedge clk);
         rx_in_last <= 1'b1;
         rx_crc_received <= r;
         rx_crc_computed <= c;
         @(posedge clk);
         rx_in_valid <= 1'b0;
         rx_in_last <= 1'b0;
         #1 chk(check_result_strobe === up && rx_out_valid === up, "frame end");
         if (up)
            chk(check_match_flag === (r == c), "match flag");
         @(posedge clk);
         #1 chk(check_result_strobe === 1'b0, "strobe too long");
      end
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(4'h0, 32'h0);
      rd(4'hC, 32'h0);
      frame(32'h1, 32'h1, 1'b0);
      chk(tx_user_take === 1'b0, "take while down");
      @(posedge clk);
      mode <= 3'h1;
      repeat (70) @(posedge clk);
      #1 chk(lane_ready_vec === 4'hF, "lanes ready");
      chk(link_ready === 1'b0, "link early");
      wait_link(1'b1, 400);
      chk(n >= 180, "partner timer short");
      rd(4'h4, 32'h1F);
      frame(32'hA5, 32'hA5, 1'b1);
      frame(32'hA5, 32'h5A, 1'b1);
      wr(4'h8, 32'h0);
      for (int i = 3; i < 5; i++)
      begin
         @(posedge clk);
         mode <= i[2:0];
         @(posedge clk);
         mode <= 3'h1;
         #1 chk(minor_fault_pulse === 1'b1, "minor pulse");
      end
      rd(4'h8, 32'h2);
      wr(4'h0, 32'h1);
      mode <= 3'h2;
      rd(4'h0, 32'h1);
      n = 0;
      while (tx_bond_start !== 1'b1 && n < 6400)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk(n < 6400 && tx_bond_busy === 1'b1 && tx_user_ready === 1'b0, "bonding start");
      repeat (4) @(posedge clk);
      #1 chk(tx_bond_busy === 1'b0 && tx_user_ready === 1'b1, "bonding length");
      repeat (2200) @(posedge clk);
      #1 chk(link_ready === 1'b1, "hotplug with any type");
      wr(4'h0, 32'h0);
      wait_link(1'b0, 2200);
      @(posedge clk);
      mode <= 3'h1;
      wait_link(1'b1, 600);
      wr(4'h0, 32'h2);
      repeat (2) @(posedge clk);
      #1 chk(link_ready === 1'b0, "restart request");
      wait_link(1'b1, 600);
      @(posedge clk);
      mode <= 3'h3;
      n = 0;
      while (lane_realign === 4'h0 && n < 40)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk(n < 40 && lane_ready_vec !== 4'hF, "realign");
      @(posedge clk);
      mode <= 3'h1;
      wait_link(1'b1, 600);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk);
         fp <= 12'h1 << (5 * k);
         repeat (3) @(posedge clk);
         #1 chk(severe_fault_flag === 1'b1, "severe flag");
         @(posedge clk);
         fp <= 12'h0;
         repeat (3) @(posedge clk);
         #1 chk(link_ready === 1'b0, "self reset");
         wait_link(1'b1, 600);
      end
      finish_test;
   end
endmodule
`default_nettype wire
